// File: shared/pcft_pkg.sv
// constants for the power-condition feature toggle
package pcft_pkg;
  localparam logic [7:0] SET_FEATURES_OPCODE = 8'hEF;
  localparam logic [7:0] POWER_COND_FEATURE = 8'h4A;
  localparam logic [3:0] SUB_ENABLE = 4'h4;
  localparam logic [3:0] SUB_DISABLE = 4'h5;
  localparam int SUB_LSB = 0;
  localparam int SUB_MSB = 3;
  localparam int IDENT_WORD = 120;
  localparam int IDENT_BIT = 7;
  // error flag positions
  localparam int ERR_ABORT_POS = 2;
  // status flag positions
  localparam int ST_BUSY_POS = 7;
  localparam int ST_READY_POS = 6;
  localparam int ST_FAULT_POS = 5;
  localparam int ST_SEEK_POS = 4;
  localparam int ST_CORR_POS = 2;
  localparam int ST_ERR_POS = 0;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  // base time unit of the timer: 100 ms at 50 MHz
  localparam int CLOCK_MHZ = 50;
  localparam int TIMER_UNIT_MS = 100;
  localparam int TIMER_UNIT_CYCLES = TIMER_UNIT_MS * 1000 * CLOCK_MHZ;
endpackage

// File: hdl/pcft_toggle.sv
// power-condition feature enable/disable command logic
`timescale 1ns/1ps
// Operation
// - sector number low nibble 4h selects enable; upper bits reserved
// - sector number low nibble 5h selects disable
// - successful enable turns the power-condition feature set on
// - successful enable sets identify word 120 bit 7
// - successful enable turns advanced power management off
// - saved timer zero: default setting loads into current setting
// - saved timer nonzero: saved setting loads into current setting
// - timer starts only if current setting nonzero and timer enabled
// - enabled state survives every reset via nonvolatile store
// - enable aborted when feature set unsupported
// - successful disable stops every running power-condition timer
// - successful disable turns the feature set off
// - successful disable clears identify word 120 bit 7
// - disabled state survives every reset via nonvolatile store
// - disable aborted while disabling or when unsupported
module pcft_toggle #(
  parameter int TIMER_W = 16,
  parameter int UNIT_CYCLES = pcft_pkg::TIMER_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_sector_number,
  input wire logic feature_supported,
  input wire logic disabling,
  input wire logic nv_enabled,
  input wire logic [TIMER_W-1:0] saved_timer,
  input wire logic [TIMER_W-1:0] default_timer,
  input wire logic current_timer_enabled,
  output logic nv_write,
  output logic nv_write_value,
  output logic extended_power_conditions_on,
  output logic advanced_power_management_off,
  output logic identify_w120_bit7,
  output logic [TIMER_W-1:0] current_timer,
  output logic timer_running,
  output logic timer_expired,
  output logic cmd_done,
  output logic [7:0] command_error_flags,
  output logic [7:0] command_status_flags
);

  ////////////////////////////////////////////////////////////////////////
  // subcommand match, used for both subcommands

  function automatic logic sub_match(
    input logic [7:0] sector_number,
    input logic [3:0] code
  );
    sub_match = sector_number[pcft_pkg::SUB_MSB:pcft_pkg::SUB_LSB] == code;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic is_ours;
  logic [3:0] sub;
  logic do_enable;
  logic do_disable;
  logic reject;
  logic accept_enable;
  logic accept_disable;

  always_comb begin
    is_ours = cmd_valid && cmd_opcode == pcft_pkg::SET_FEATURES_OPCODE
      && cmd_feature == pcft_pkg::POWER_COND_FEATURE;
    sub = cmd_sector_number[pcft_pkg::SUB_MSB:pcft_pkg::SUB_LSB];
    do_enable = is_ours
      && sub_match(cmd_sector_number, pcft_pkg::SUB_ENABLE);
    do_disable = is_ours
      && sub_match(cmd_sector_number, pcft_pkg::SUB_DISABLE);
    reject = (do_enable && !feature_supported)
      || (do_disable && (!feature_supported || disabling));
    accept_enable = do_enable && !reject;
    accept_disable = do_disable && !reject;
  end

  ////////////////////////////////////////////////////////////////////////
  // feature state, reloaded from the nonvolatile copy at reset

  logic feature_on_r;
  logic apm_off_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      feature_on_r <= nv_enabled;
    end else if (accept_enable) begin
      feature_on_r <= 1'b1;
    end else if (accept_disable) begin
      feature_on_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      apm_off_r <= nv_enabled;
    end else if (accept_enable) begin
      apm_off_r <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      nv_write <= 1'b0;
      nv_write_value <= 1'b0;
    end else begin
      nv_write <= accept_enable || accept_disable;
      nv_write_value <= accept_enable;
    end
  end

  assign extended_power_conditions_on = feature_on_r;
  assign advanced_power_management_off = apm_off_r;
  assign identify_w120_bit7 = feature_on_r;

  ////////////////////////////////////////////////////////////////////////
  // current timer setting and timer

  logic [TIMER_W-1:0] current_r;
  logic running_r;
  logic [TIMER_W-1:0] units_r;
  logic [31:0] tick_r;
  logic [TIMER_W-1:0] load_value;
  logic expired_r;

  assign load_value = (saved_timer == '0) ? default_timer
    : saved_timer;

  always_ff @(posedge clock) begin
    if (rst) begin
      current_r <= TIMER_W'(pcft_pkg::TIMER_RESET);
    end else if (accept_enable) begin
      current_r <= load_value;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      running_r <= 1'b0;
      units_r <= '0;
      tick_r <= '0;
      expired_r <= 1'b0;
    end else begin
      expired_r <= 1'b0;
      if (accept_disable) begin
        running_r <= 1'b0;
      end else if (accept_enable) begin
        running_r <= load_value != '0 && current_timer_enabled;
        units_r <= load_value;
        tick_r <= '0;
      end else if (running_r) begin
        if (tick_r == 32'(UNIT_CYCLES - 1)) begin
          tick_r <= '0;
          if (units_r <= TIMER_W'(1)) begin
            running_r <= 1'b0;
            expired_r <= 1'b1;
          end else begin
            units_r <= units_r - TIMER_W'(1);
          end
        end else begin
          tick_r <= tick_r + 32'd1;
        end
      end
    end
  end

  assign current_timer = current_r;
  assign timer_running = running_r;
  assign timer_expired = expired_r;

  ////////////////////////////////////////////////////////////////////////
  // completion registers

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_done <= 1'b0;
      command_error_flags <= pcft_pkg::ERR_RESET;
      command_status_flags <= pcft_pkg::STATUS_RESET;
    end else begin
      cmd_done <= do_enable || do_disable;
      if (do_enable || do_disable) begin
        command_error_flags <= pcft_pkg::ERR_RESET;
        command_error_flags[pcft_pkg::ERR_ABORT_POS] <= reject;
        command_status_flags <= pcft_pkg::STATUS_RESET;
        command_status_flags[pcft_pkg::ST_ERR_POS] <= reject;
      end
    end
  end

endmodule // pcft_toggle

// File: verification/pcft_properties.sv
// port assertions for the toggle
`timescale 1ns/1ps
module pcft_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_sector_number,
  input wire logic feature_supported,
  input wire logic disabling,
  input wire logic extended_power_conditions_on,
  input wire logic advanced_power_management_off,
  input wire logic identify_w120_bit7,
  input wire logic timer_running,
  input wire logic cmd_done,
  input wire logic [7:0] command_error_flags,
  input wire logic [7:0] command_status_flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic hit;
  logic en;
  logic dis;
  logic dis_ok;
  assign hit = cmd_valid && cmd_opcode == 8'hEF && cmd_feature == 8'h4A;
  assign en = hit && cmd_sector_number[3:0] == 4'h4;
  assign dis = hit && cmd_sector_number[3:0] == 4'h5;
  assign dis_ok = dis && feature_supported && !disabling;
  chk_enable_sets_on: assert property (en && feature_supported |=>
    extended_power_conditions_on && identify_w120_bit7
    && command_status_flags == 8'h50) else $error("enable state");
  chk_enable_apm_off: assert property (en && feature_supported |=>
    advanced_power_management_off) else $error("power management on");
  chk_disable_clears: assert property (dis_ok |=>
    !extended_power_conditions_on && !identify_w120_bit7) else $error("dis");
  chk_disable_stops: assert property (dis_ok |=>
    !timer_running) else $error("timer still running");
  chk_enable_refused: assert property (en && !feature_supported |=>
    command_status_flags == 8'h51 && command_error_flags == 8'h04)
    else $error("enable not refused");
  chk_disable_refused: assert property (dis && !dis_ok |=>
    command_status_flags == 8'h51 && command_error_flags == 8'h04)
    else $error("disable not refused");
  chk_done_after_take: assert property ((en || dis) |=> cmd_done)
    else $error("no completion");
  chk_other_ignored: assert property (hit && !en && !dis |=> !cmd_done)
    else $error("other code completed");
endmodule // pcft_chk
bind pcft_toggle pcft_chk u_chk (.*);

// File: verification/pcft_host.sv
// host command issuer and nonvolatile store
`timescale 1ns/1ps
module pcft_host (
  input wire logic clock,
  input wire logic nv_write,
  input wire logic nv_write_value,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_feature,
  output logic [7:0] cmd_sector_number,
  output logic nv_enabled
);
  initial nv_enabled = 1'b0;
  initial cmd_valid = 1'b0;
  initial cmd_opcode = 8'h00;
  initial cmd_feature = 8'h00;
  initial cmd_sector_number = 8'h00;
  always @(posedge clock) if (nv_write) nv_enabled <= nv_write_value;
  task automatic issue(input logic [7:0] sn);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_opcode = 8'hEF;
    cmd_feature = 8'h4A;
    cmd_sector_number = sn;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_opcode = 8'h10;
    cmd_feature = 8'hB5;
    cmd_sector_number = ~sn;
  endtask
endmodule // pcft_host

// File: verification/testbench.sv
// self-checking bench for the toggle
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
  logic clock = 0;
  logic rst;
  logic feature_supported;
  logic disabling;
  logic current_timer_enabled;
  logic [15:0] saved_timer;
  logic [15:0] default_timer;
  logic [15:0] current_timer;
  logic [7:0] cmd_opcode, cmd_feature, cmd_sector_number;
  logic [7:0] command_error_flags, command_status_flags;
  logic cmd_valid, nv_enabled, nv_write, nv_write_value, cmd_done;
  logic extended_power_conditions_on, advanced_power_management_off;
  logic identify_w120_bit7, timer_running, timer_expired;
  int bad_count = 0;
  int tests_run = 0;
  always #10 clock = ~clock;
  pcft_host host (.*);
  pcft_toggle #(.UNIT_CYCLES(4)) DUT (.*);
  task rs;
    rst = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    feature_supported = 1'b1;
    disabling = 1'b0;
    current_timer_enabled = 1'b1;
    saved_timer = 16'h0000;
    default_timer = 16'h0003;
    rs();
    `CHK("stat", 8'h50, command_status_flags)
    host.issue(8'hF4);
    `CHK("done", 1'b1, cmd_done)
    `CHK("ident", 1'b1, identify_w120_bit7)
    `CHK("apm", 1'b1, advanced_power_management_off)
    `CHK("dflt", 16'h0003, current_timer)
    `CHK("run", 1'b1, timer_running)
    for (int i = 0; i < 40 && timer_expired !== 1'b1; i++) @(negedge clock);
    `CHK("exp", 1'b1, timer_expired)
    saved_timer = 16'h0007;
    current_timer_enabled = 1'b0;
    host.issue(8'h04);
    `CHK("saved", 16'h0007, current_timer)
    `CHK("idle", 1'b0, timer_running)
    rs();
    `CHK("keep", 1'b1, extended_power_conditions_on)
    current_timer_enabled = 1'b1;
    host.issue(8'h04);
    host.issue(8'h05);
    `CHK("stop", 1'b0, timer_running)
    `CHK("clr", 1'b0, identify_w120_bit7)
    rs();
    `CHK("kept", 1'b0, extended_power_conditions_on)
    disabling = 1'b1;
    host.issue(8'h05);
    `CHK("abt", 8'h04, command_error_flags)
    `CHK("err", 8'h51, command_status_flags)
    disabling = 1'b0;
    feature_supported = 1'b0;
    host.issue(8'h04);
    `CHK("rej", 8'h51, command_status_flags)
    `CHK("same", 1'b0, extended_power_conditions_on)
    host.issue(8'h06);
    `CHK("ign", 1'b0, cmd_done)
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule // testbench
